// ---- dmapl_params.svh ----
// Offsets, field positions and reset values of the DMA channel programming logic.
// Assumes a 16-bit I/O address and 8-bit data on the register port.
`ifndef DMAPL_PARAMS_SVH
`define DMAPL_PARAMS_SVH

`define DMAPL_AW 16
`define DMAPL_DW 8

// I/O locations, low unit and high unit
`define DMAPL_CMD_STAT_LO 16'h0008
`define DMAPL_CMD_STAT_HI 16'h00d0
`define DMAPL_REQ_LO 16'h0009
`define DMAPL_REQ_HI 16'h00d2
`define DMAPL_SMASK_LO 16'h000a
`define DMAPL_SMASK_HI 16'h00d4
`define DMAPL_MODE_LO 16'h000b
`define DMAPL_MODE_HI 16'h00d6
`define DMAPL_CLR_PTR_LO 16'h000c
`define DMAPL_CLR_PTR_HI 16'h00d8
`define DMAPL_MCLR_LO 16'h000d
`define DMAPL_MCLR_HI 16'h00da
`define DMAPL_CLR_MASK_LO 16'h000e
`define DMAPL_CLR_MASK_HI 16'h00dc
`define DMAPL_AMASK_LO 16'h000f
`define DMAPL_AMASK_HI 16'h00de
`define DMAPL_SET_PTR_LO 16'h0010
`define DMAPL_SET_PTR_HI 16'h00e0
`define DMAPL_CLR_MCNT_LO 16'h0011
`define DMAPL_CLR_MCNT_HI 16'h00e2
// Address and word count window, byte-wise access
`define DMAPL_ACWIN_LO_FIRST 16'h0000
`define DMAPL_ACWIN_LO_LAST 16'h0007
`define DMAPL_ACWIN_HI_FIRST 16'h00c0
`define DMAPL_ACWIN_HI_LAST 16'h00cf

// Field positions
`define DMAPL_CHSEL_MSB 1
`define DMAPL_CHSEL_LSB 0
`define DMAPL_MODE_MSB 7
`define DMAPL_MODE_LSB 2
`define DMAPL_REQ_SET_BIT 2
`define DMAPL_MASK_SET_BIT 2
`define DMAPL_CMD_DRQ_LOW_BIT 6

// Reset values and read-back fill values
`define DMAPL_MASK_RST 4'hf
`define DMAPL_CMD_RST 8'h00
`define DMAPL_MODE_RST 6'h00
`define DMAPL_FILL_HI 4'hf
`define DMAPL_MODE_RD_LOW 2'h3
`define DMAPL_UNDEF_RD 8'hff

`endif

// ---- dmapl_pkg.sv ----
// Types of the DMA channel programming logic.
// Assumes nothing beyond the parameter header.
package dmapl_pkg;

  typedef enum logic [1:0] {
    DMAPL_XFER_VERIFY,
    DMAPL_XFER_WRITE,
    DMAPL_XFER_READ,
    DMAPL_XFER_UNUSED
  } dmapl_xfer_e;

  typedef enum logic [1:0] {
    DMAPL_SVC_DEMAND,
    DMAPL_SVC_SINGLE,
    DMAPL_SVC_BLOCK,
    DMAPL_SVC_CASCADE
  } dmapl_svc_e;

  // Mode byte bits 7:2 of one channel
  typedef struct packed {
    dmapl_svc_e svc;
    logic addr_dec;
    logic auto_init;
    dmapl_xfer_e xfer;
  } dmapl_mode_s;

endpackage : dmapl_pkg

// ---- dmapl_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; DEPTH a power of two so pointers wrap naturally.
`timescale 1ns/1ps
`default_nettype none
module dmapl_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output var logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output var logic out_valid_o,
  input wire logic out_ready_i,
  output var logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("dmapl_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      // Registered ready: full is known one cycle ahead, never overflows
      in_ready_o <= (count_d != (AW+1)'(DEPTH));
    end
  end
endmodule : dmapl_fifo
`default_nettype wire

// ---- dmapl_prog.sv ----
// Programming section of a four-channel DMA controller: mode, request,
// mask, status and special commands on an 8-bit I/O register port.
// Assumes I/O requests and terminal-count pulses on clk_i; requests from
// peripherals arrive asynchronously on channel_request_in_i.
`timescale 1ns/1ps
`default_nettype none
`include "dmapl_params.svh"
module dmapl_prog
  import dmapl_pkg::*;
#(
  parameter bit UNIT_HI = 1'b0,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic io_req_valid_i,
  input wire logic io_req_wr_i,
  input wire logic [`DMAPL_AW-1:0] io_addr_i,
  input wire logic [`DMAPL_DW-1:0] io_wdata_i,
  output var logic io_req_ready_o,
  output var logic io_rvalid_o,
  output var logic [`DMAPL_DW-1:0] io_rdata_o,
  input wire logic cfg_hold_i,
  input wire logic [3:0] channel_request_in_i,
  input wire logic [3:0] tc_i,
  output var logic [3:0] mask_o,
  output var logic [3:0] sw_req_o,
  output var logic [3:0] req_pending_o,
  output var logic [3:0] auto_init_o,
  output var logic [3:0] addr_dec_o,
  output var logic [7:0] xfer_kind_o,
  output var logic [7:0] service_kind_o,
  output var logic [7:0] command_o,
  output var logic byte_ptr_hi_o,
  output var logic [3:0] addr_reload_o,
  output var logic master_clear_o
);
  localparam int EW = 1 + `DMAPL_AW + `DMAPL_DW;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("dmapl_prog: FIFO_DEPTH must be at least 2");
    end
  end

  function automatic logic at(input logic [`DMAPL_AW-1:0] a,
                              input logic [`DMAPL_AW-1:0] lo,
                              input logic [`DMAPL_AW-1:0] hi);
    at = (a == (UNIT_HI ? hi : lo));
  endfunction : at

  function automatic logic in_acwin(input logic [`DMAPL_AW-1:0] a);
    if (UNIT_HI) begin
      in_acwin = (a >= `DMAPL_ACWIN_HI_FIRST) && (a <= `DMAPL_ACWIN_HI_LAST);
    end else begin
      in_acwin = (a <= `DMAPL_ACWIN_LO_LAST);
    end
  endfunction : in_acwin

  // Command FIFO: reads and writes keep their order, and the transfer
  // engine can hold programming off without losing CPU accesses
  logic [EW-1:0] fifo_in;
  logic [EW-1:0] fifo_out;
  logic fifo_valid;
  logic pop;
  logic op_wr;
  logic [`DMAPL_AW-1:0] op_addr;
  logic [`DMAPL_DW-1:0] op_data;

  assign fifo_in = {io_req_wr_i, io_addr_i, io_wdata_i};

  dmapl_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(io_req_valid_i),
    .in_ready_o(io_req_ready_o),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_valid),
    .out_ready_i(!cfg_hold_i),
    .out_data_o(fifo_out)
  );

  assign pop = fifo_valid & !cfg_hold_i;
  assign op_wr = fifo_out[EW-1];
  assign op_addr = fifo_out[EW-2 -: `DMAPL_AW];
  assign op_data = fifo_out[`DMAPL_DW-1:0];

  // Access decode
  logic wr_op;
  logic rd_op;
  logic any_op;
  logic hit_cmd;
  logic hit_req;
  logic hit_smask;
  logic hit_mode;
  logic hit_amask;
  logic do_clr_ptr;
  logic do_set_ptr;
  logic do_mclr;
  logic do_clr_mask;
  logic do_clr_mcnt;
  logic do_acwin;
  logic [1:0] chsel;
  logic [3:0] ch_onehot;

  assign wr_op = pop & op_wr;
  assign rd_op = pop & !op_wr;
  assign any_op = pop;
  assign hit_cmd = at(op_addr, `DMAPL_CMD_STAT_LO, `DMAPL_CMD_STAT_HI);
  assign hit_req = at(op_addr, `DMAPL_REQ_LO, `DMAPL_REQ_HI);
  assign hit_smask = at(op_addr, `DMAPL_SMASK_LO, `DMAPL_SMASK_HI);
  assign hit_mode = at(op_addr, `DMAPL_MODE_LO, `DMAPL_MODE_HI);
  assign hit_amask = at(op_addr, `DMAPL_AMASK_LO, `DMAPL_AMASK_HI);
  // Special commands fire on either direction; write data is unused
  assign do_clr_ptr = any_op & at(op_addr, `DMAPL_CLR_PTR_LO, `DMAPL_CLR_PTR_HI);
  assign do_set_ptr = any_op & at(op_addr, `DMAPL_SET_PTR_LO, `DMAPL_SET_PTR_HI);
  assign do_mclr = any_op & at(op_addr, `DMAPL_MCLR_LO, `DMAPL_MCLR_HI);
  assign do_clr_mask = any_op & at(op_addr, `DMAPL_CLR_MASK_LO, `DMAPL_CLR_MASK_HI);
  assign do_clr_mcnt = any_op & at(op_addr, `DMAPL_CLR_MCNT_LO, `DMAPL_CLR_MCNT_HI);
  assign do_acwin = any_op & in_acwin(op_addr);
  assign chsel = op_data[`DMAPL_CHSEL_MSB:`DMAPL_CHSEL_LSB];
  assign ch_onehot = 4'b0001 << chsel;

  // Request input synchroniser
  logic [3:0] drq_meta_q;
  logic [3:0] drq_sync_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drq_meta_q <= '0;
      drq_sync_q <= '0;
    end else begin
      drq_meta_q <= channel_request_in_i;
      drq_sync_q <= drq_meta_q;
    end
  end

  // Command register; bit 6 picks the active level of the request pins
  logic [7:0] cmd_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_q <= `DMAPL_CMD_RST;
    end else if (do_mclr) begin
      cmd_q <= `DMAPL_CMD_RST;
    end else if (wr_op && hit_cmd) begin
      cmd_q <= op_data;
    end
  end

  // Mode registers; master clear leaves them alone
  dmapl_mode_s mode_q [4];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        mode_q[i] <= dmapl_mode_s'(`DMAPL_MODE_RST);
      end
    end else if (wr_op && hit_mode) begin
      mode_q[chsel] <= dmapl_mode_s'(op_data[`DMAPL_MODE_MSB:`DMAPL_MODE_LSB]);
    end
  end

  logic [3:0] auto_init;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      auto_init[i] = mode_q[i].auto_init;
      auto_init_o[i] = mode_q[i].auto_init;
      addr_dec_o[i] = mode_q[i].addr_dec;
      xfer_kind_o[2*i +: 2] = mode_q[i].xfer;
      service_kind_o[2*i +: 2] = mode_q[i].svc;
    end
  end

  // Mode read counter
  logic [1:0] mode_rd_ptr_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_rd_ptr_q <= '0;
    end else if (do_mclr || do_clr_mcnt) begin
      mode_rd_ptr_q <= '0;
    end else if (rd_op && hit_mode) begin
      mode_rd_ptr_q <= mode_rd_ptr_q + 2'd1;
    end
  end

  // Software requests, never gated by the mask
  logic [3:0] swreq_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      swreq_q <= '0;
    end else if (do_mclr) begin
      swreq_q <= '0;
    end else if (wr_op && hit_req) begin
      if (op_data[`DMAPL_REQ_SET_BIT]) begin
        swreq_q <= swreq_q | ch_onehot;
      end else begin
        swreq_q <= swreq_q & ~ch_onehot;
      end
    end
  end

  // Masks; terminal count setting a mask wins over any clear that cycle
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [3:0] tc_mask_set;

  assign tc_mask_set = tc_i & ~auto_init;

  always_comb begin
    mask_d = mask_q;
    if (do_clr_mask) begin
      mask_d = '0;
    end else if (wr_op && hit_amask) begin
      mask_d = op_data[3:0];
    end else if (wr_op && hit_smask) begin
      if (op_data[`DMAPL_MASK_SET_BIT]) begin
        mask_d = mask_q | ch_onehot;
      end else begin
        mask_d = mask_q & ~ch_onehot;
      end
    end
    if (do_mclr) begin
      mask_d = `DMAPL_MASK_RST;
    end
    mask_d = mask_d | tc_mask_set;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= `DMAPL_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Terminal count flags; a new count in the clearing cycle survives
  logic [3:0] tc_flag_q;
  logic tc_clr;

  assign tc_clr = do_mclr | (rd_op & hit_cmd);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tc_flag_q <= '0;
    end else begin
      tc_flag_q <= (tc_flag_q & ~{4{tc_clr}}) | tc_i;
    end
  end

  // Pending flags follow the request level, independent of the mask
  logic [3:0] pend_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= '0;
    end else if (do_mclr) begin
      pend_q <= '0;
    end else begin
      pend_q <= drq_sync_q ^ {4{cmd_q[`DMAPL_CMD_DRQ_LOW_BIT]}};
    end
  end

  // Byte pointer for the address and count registers
  logic byte_ptr_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byte_ptr_q <= 1'b0;
    end else if (do_mclr || do_clr_ptr) begin
      byte_ptr_q <= 1'b0;
    end else if (do_set_ptr) begin
      byte_ptr_q <= 1'b1;
    end else if (do_acwin) begin
      byte_ptr_q <= !byte_ptr_q;
    end
  end

  // Event outputs to the transfer engine
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reload_o <= '0;
      master_clear_o <= 1'b0;
    end else begin
      addr_reload_o <= tc_i & auto_init;
      master_clear_o <= do_mclr;
    end
  end

  // Read answer, one cycle after the access leaves the FIFO
  logic [`DMAPL_DW-1:0] rdata_d;

  always_comb begin
    rdata_d = `DMAPL_UNDEF_RD;
    if (hit_cmd) begin
      rdata_d = {pend_q, tc_flag_q};
    end else if (hit_mode) begin
      rdata_d = {mode_q[mode_rd_ptr_q], `DMAPL_MODE_RD_LOW};
    end else if (hit_req) begin
      rdata_d = {`DMAPL_FILL_HI, swreq_q};
    end else if (hit_amask) begin
      rdata_d = {`DMAPL_FILL_HI, mask_q};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_rvalid_o <= 1'b0;
      io_rdata_o <= '0;
    end else begin
      io_rvalid_o <= rd_op;
      if (rd_op) begin
        io_rdata_o <= rdata_d;
      end
    end
  end

  assign mask_o = mask_q;
  assign sw_req_o = swreq_q;
  assign req_pending_o = pend_q;
  assign command_o = cmd_q;
  assign byte_ptr_hi_o = byte_ptr_q;
endmodule : dmapl_prog
`default_nettype wire

// ---- dmapl_prog_asserts.sv ----
// Checker for the DMA programming block, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dmapl_prog_asserts (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic io_req_ready_o,
  input wire logic [3:0] channel_request_in_i,
  input wire logic [3:0] tc_i,
  input wire logic [3:0] mask_o,
  input wire logic [3:0] sw_req_o,
  input wire logic [3:0] req_pending_o,
  input wire logic [3:0] auto_init_o,
  input wire logic [7:0] command_o,
  input wire logic byte_ptr_hi_o,
  input wire logic [3:0] addr_reload_o,
  input wire logic master_clear_o
);
  logic [3:0] tc_na;
  logic [3:0] tc_ai;
  assign tc_na = tc_i & ~auto_init_o;
  assign tc_ai = tc_i & auto_init_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_tc_mask;
    tc_na != 4'h0 |=> (mask_o & $past(tc_na)) == $past(tc_na);
  endproperty
  a_tc_mask: assert property (p_tc_mask) else $error("mask not set at count end");
  property p_reload;
    addr_reload_o == $past(tc_ai);
  endproperty
  a_reload: assert property (p_reload) else $error("reload pulse wrong");
  property p_rst;
    !$past(nrst_i) |-> mask_o == 4'hf && sw_req_o == 4'h0 && !io_req_ready_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_mclr_mask;
    master_clear_o |-> mask_o == 4'hf;
  endproperty
  a_mclr_mask: assert property (p_mclr_mask) else $error("masks not set by clear");
  property p_mclr_regs;
    master_clear_o |-> sw_req_o == 4'h0 && command_o == 8'h00 && !byte_ptr_hi_o;
  endproperty
  a_mclr_regs: assert property (p_mclr_regs) else $error("clear left state");
  property p_mclr_pend;
    master_clear_o |-> ##[0:1] req_pending_o == 4'h0;
  endproperty
  a_mclr_pend: assert property (p_mclr_pend) else $error("pending not cleared");
  // Five quiet cycles cover the two-flop synchroniser and the clear dip
  property p_pend;
    ($stable(channel_request_in_i) && $stable(command_o) && !master_clear_o) [*5]
      |-> req_pending_o == (channel_request_in_i ^ {4{command_o[6]}});
  endproperty
  a_pend: assert property (p_pend) else $error("pending flags off pins");
  property p_mask_sw;
    $changed(mask_o) && !master_clear_o && $past(tc_i) == 4'h0 |-> $stable(sw_req_o);
  endproperty
  a_mask_sw: assert property (p_mask_sw) else $error("mask touched requests");
endmodule : dmapl_prog_asserts
bind dmapl_prog dmapl_prog_asserts i_dmapl_prog_asserts (
  .clk_i, .nrst_i, .io_req_ready_o, .channel_request_in_i, .tc_i, .mask_o,
  .sw_req_o, .req_pending_o, .auto_init_o, .command_o, .byte_ptr_hi_o,
  .addr_reload_o, .master_clear_o
);
`default_nettype wire

// ---- dmapl_periph.sv ----
// Peripheral side: four request lines whose level the bench chooses.
// Assumes the bench mirrors command bit 6 so wire polarity follows it.
`timescale 1ns/1ps
`default_nettype none
module dmapl_periph #(
  parameter realtime LAG = 2.3
) (
  input wire logic [3:0] want_i,
  input wire logic act_low_i,
  output var logic [3:0] channel_request_in_o
);
  // Lines move off the clock grid, so the block must synchronise them
  assign #(LAG) channel_request_in_o = want_i ^ {4{act_low_i}};
endmodule : dmapl_periph
`default_nettype wire

// ---- dmapl_tb.sv ----
// Self-checking bench for the DMA programming block with a reference model.
// Assumes in-order read answers and the peripheral model on the request pins.
`timescale 1ns/1ps
`default_nettype none
`include "dmapl_params.svh"
module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic hold = 1'b0;
  logic [3:0] tc = 4'h0;
  logic [3:0] want = 4'h0;
  logic [3:0] pins, mask, swr, pend, ai, ad, rel;
  logic [7:0] rdata, cmd, xk, sk;
  logic rdy, rv, ptr, mclr;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [5:0] m_mode [4];
  logic [3:0] m_mask, m_req, m_tc, m_ai;
  logic [7:0] m_cmd = 8'h00;
  logic [1:0] m_mcnt;
  logic m_ptr;
  always #2.5 clk_i = ~clk_i;
  dmapl_prog i_dmapl_prog (
    .clk_i(clk_i), .nrst_i(nrst_i), .io_req_valid_i(vld), .io_req_wr_i(wr),
    .io_addr_i(addr), .io_wdata_i(wdata), .io_req_ready_o(rdy), .io_rvalid_o(rv),
    .io_rdata_o(rdata), .cfg_hold_i(hold), .channel_request_in_i(pins), .tc_i(tc),
    .mask_o(mask), .sw_req_o(swr), .req_pending_o(pend), .auto_init_o(ai),
    .addr_dec_o(ad), .xfer_kind_o(xk), .service_kind_o(sk), .command_o(cmd),
    .byte_ptr_hi_o(ptr), .addr_reload_o(rel), .master_clear_o(mclr)
  );
  dmapl_periph i_dmapl_periph (
    .want_i(want), .act_low_i(m_cmd[6]), .channel_request_in_o(pins)
  );
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t port got %h exp %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic put(input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    #1;
    vld = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    for (i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge clk_i);
    if (i == 200) error_cnt++;
    @(posedge clk_i);
    #1;
    vld = 1'b0;
  endtask : put
  // Special commands fire on reads and writes alike
  task automatic fx(input logic [15:0] a);
    case (a)
      `DMAPL_CLR_PTR_LO: m_ptr = 1'b0;
      `DMAPL_SET_PTR_LO: m_ptr = 1'b1;
      `DMAPL_CLR_MASK_LO: m_mask = 4'h0;
      `DMAPL_CLR_MCNT_LO: m_mcnt = 2'h0;
      `DMAPL_MCLR_LO: begin
        m_cmd = 8'h00;
        m_req = 4'h0;
        m_tc = 4'h0;
        m_mcnt = 2'h0;
        m_ptr = 1'b0;
        m_mask = 4'hf;
      end
      default: if (a <= `DMAPL_ACWIN_LO_LAST) m_ptr = ~m_ptr;
    endcase
  endtask : fx
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    put(1'b1, a, d);
    case (a)
      `DMAPL_MODE_LO: m_mode[d[1:0]] = d[7:2];
      `DMAPL_REQ_LO: m_req[d[1:0]] = d[2];
      `DMAPL_SMASK_LO: m_mask[d[1:0]] = d[2];
      `DMAPL_AMASK_LO: m_mask = d[3:0];
      `DMAPL_CMD_STAT_LO: m_cmd = d;
      default: fx(a);
    endcase
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a);
    logic [7:0] exp;
    int i;
    exp = 8'hff;
    if (a == `DMAPL_MODE_LO) exp = {m_mode[m_mcnt], 2'b11};
    if (a == `DMAPL_REQ_LO) exp = {4'hf, m_req};
    if (a == `DMAPL_AMASK_LO) exp = {4'hf, m_mask};
    if (a == `DMAPL_CMD_STAT_LO) exp = {want, m_tc};
    if (a == `DMAPL_MODE_LO) m_mcnt++;
    if (a == `DMAPL_CMD_STAT_LO) m_tc = 4'h0;
    fx(a);
    put(1'b0, a, 8'($urandom));
    for (i = 0; i < 200 && rv !== 1'b1; i++) @(negedge clk_i);
    if (i == 200) error_cnt++;
    chk_rd(rdata, exp);
  endtask : rd_reg
  task automatic tend(input string name);
    $display("test %s ended, mismatches so far %0d", name, error_cnt);
  endtask : tend
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    int c;
    void'($urandom(44));
    for (c = 0; c < 4; c++) m_mode[c] = 6'h00;
    {m_mask, m_req, m_tc, m_mcnt, m_ptr} = {4'hf, 4'h0, 4'h0, 2'h0, 1'b0};
    repeat (12) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    chk_out({mask, swr}, 8'hf0);
    rd_reg(`DMAPL_CMD_STAT_LO);
    tend("reset");
    for (c = 0; c < 4; c++) wr_reg(`DMAPL_MODE_LO, {2'(3 - c), 2'($urandom), c[1:0], c[1:0]});
    rd_reg(16'h0050);
    for (c = 0; c < 4; c++) begin
      chk_out({xk[2*c+:2], sk[2*c+:2], ad[c], ai[c], 2'b00}, {m_mode[c][1:0],
        m_mode[c][5:4], m_mode[c][3], m_mode[c][2], 2'b00});
    end
    wr_reg(`DMAPL_CLR_MCNT_LO, 8'($urandom));
    for (c = 0; c < 4; c++) rd_reg(`DMAPL_MODE_LO);
    tend("mode");
    for (c = 0; c < 4; c++) wr_reg(`DMAPL_REQ_LO, {6'($urandom), c[1:0]});
    rd_reg(`DMAPL_REQ_LO);
    chk_out({mask, swr}, {m_mask, m_req});
    tend("request");
    for (c = 0; c < 4; c++) wr_reg(`DMAPL_SMASK_LO, 8'($urandom));
    rd_reg(`DMAPL_AMASK_LO);
    wr_reg(`DMAPL_AMASK_LO, 8'($urandom));
    rd_reg(`DMAPL_AMASK_LO);
    rd_reg(`DMAPL_CLR_MASK_LO);
    rd_reg(`DMAPL_AMASK_LO);
    tend("mask");
    wr_reg(`DMAPL_MODE_LO, 8'h00);
    wr_reg(`DMAPL_MODE_LO, 8'h11);
    rd_reg(16'h0050);
    @(posedge clk_i);
    #1 tc = 4'hf;
    @(posedge clk_i);
    #1 tc = 4'h0;
    for (c = 0; c < 4; c++) m_ai[c] = m_mode[c][2];
    chk_out({4'h0, rel}, {4'h0, m_ai});
    m_tc = 4'hf;
    for (c = 0; c < 4; c++) if (!m_mode[c][2]) m_mask[c] = 1'b1;
    rd_reg(`DMAPL_CMD_STAT_LO);
    rd_reg(`DMAPL_CMD_STAT_LO);
    chk_out({mask, swr}, {m_mask, m_req});
    tend("terminal count");
    @(posedge clk_i);
    #1 want = 4'($urandom);
    wr_reg(`DMAPL_AMASK_LO, 8'h0f);
    repeat (6) @(posedge clk_i);
    rd_reg(`DMAPL_CMD_STAT_LO);
    chk_out({4'h0, pend}, {4'h0, want});
    wr_reg(`DMAPL_CMD_STAT_LO, 8'h40);
    repeat (6) @(posedge clk_i);
    rd_reg(`DMAPL_CMD_STAT_LO);
    chk_out(cmd, m_cmd);
    @(posedge clk_i);
    #1 want = 4'h0;
    repeat (6) @(posedge clk_i);
    rd_reg(`DMAPL_CMD_STAT_LO);
    tend("pending");
    wr_reg(`DMAPL_CLR_PTR_LO, 8'($urandom));
    wr_reg(`DMAPL_ACWIN_LO_FIRST, 8'($urandom));
    rd_reg(16'h0050);
    chk_out({7'h00, ptr}, {7'h00, m_ptr});
    wr_reg(`DMAPL_ACWIN_LO_LAST, 8'($urandom));
    rd_reg(`DMAPL_SET_PTR_LO);
    chk_out({7'h00, ptr}, {7'h00, m_ptr});
    tend("pointer");
    @(posedge clk_i);
    #1 hold = 1'b1;
    for (c = 0; c < 16; c++) wr_reg(`DMAPL_SMASK_LO, 8'($urandom));
    @(posedge clk_i);
    @(negedge clk_i);
    chk_out({7'h00, rdy}, 8'h00);
    @(posedge clk_i);
    #1 hold = 1'b0;
    rd_reg(`DMAPL_AMASK_LO);
    tend("buffer");
    wr_reg(`DMAPL_REQ_LO, 8'h07);
    wr_reg(`DMAPL_CLR_MASK_LO, 8'($urandom));
    rd_reg(`DMAPL_MODE_LO);
    rd_reg(`DMAPL_MCLR_LO);
    chk_out({mask, swr}, {m_mask, m_req});
    chk_out({cmd[6:0], ptr}, {m_cmd[6:0], m_ptr});
    rd_reg(`DMAPL_MODE_LO);
    rd_reg(`DMAPL_CMD_STAT_LO);
    tend("master clear");
    // Reset in mid-run must restore the same state as at power-up
    wr_reg(`DMAPL_REQ_LO, 8'h06);
    @(posedge clk_i);
    #1 nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    for (c = 0; c < 4; c++) m_mode[c] = 6'h00;
    {m_mask, m_req, m_tc, m_mcnt, m_ptr, m_cmd} = {4'hf, 4'h0, 4'h0, 2'h0, 1'b0, 8'h00};
    chk_out({mask, swr}, {m_mask, m_req});
    rd_reg(`DMAPL_MODE_LO);
    tend("second reset");
    test_done();
  end
endmodule : tb
`default_nettype wire
